// [bclt_pkg.sv]
// package of timing constants, states and carriers for the cc line timing block
package bclt_pkg;

    // ------------------------------------------------------------------
    // clock and documented times in nanoseconds, drift limit in percent, transition count
    // ------------------------------------------------------------------
    localparam int CLK_NS           = 50;      // 20 MHz
    localparam int UI_NS            = 3333;    // running_bit_rate nominal 300 kbps
    localparam int HOLD_LOW_NS      = 1000;    // least low hold after last bit
    localparam int END_DRIVE_NS     = 23000;   // end_of_drive_time, longest
    localparam int GAP_NS           = 25000;   // inter_frame_gap_time, least
    localparam int START_TOL_NS     = 1000;    // start_drive_tolerance, either way
    localparam int FRS_TX_MIN_NS    = 60000;   // role_swap_pulse_duration, least
    localparam int FRS_TX_MAX_NS    = 120000;  // role_swap_pulse_duration, longest
    localparam int FRS_TX_NS        = 90000;   // chosen pulse, mid range
    localparam int FRS_RX_MIN_NS    = 30000;   // role_swap_detect_time, least
    localparam int FRS_RX_MAX_NS    = 50000;   // role_swap_detect_time, longest
    localparam int FRS_RX_NS        = 40000;   // chosen detect threshold
    localparam int WIN_MIN_NS       = 12000;   // activity_detect_window, least
    localparam int WIN_MAX_NS       = 20000;   // activity_detect_window, longest
    localparam int WIN_NS           = 16000;   // chosen window
    localparam int FILT_TAU_MIN_NS  = 100;     // receive_filter_time_constant
    localparam int DRIFT_LIMIT_PCT  = 3;       // bit_rate_drift_limit
    localparam int TRANS_COUNT      = 3;       // activity_transition_count

    // ------------------------------------------------------------------
    // cycle counts derived from the times
    // ------------------------------------------------------------------
    localparam logic [10:0] HALF_UI_CYC  = 11'(UI_NS / 2 / CLK_NS);
    localparam logic [10:0] HOLD_CYC     = 11'((HOLD_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] END_DRV_CYC  = 11'(END_DRIVE_NS / CLK_NS);
    localparam logic [9:0]  GAP_CYC      = 10'((GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] FRS_TX_CYC   = 11'(FRS_TX_NS / CLK_NS);
    localparam logic [9:0]  FRS_RX_CYC   = 10'(FRS_RX_NS / CLK_NS);
    localparam logic [8:0]  WIN_CYC      = 9'(WIN_NS / CLK_NS);
    localparam logic [1:0]  TRANS_LAST   = 2'(TRANS_COUNT - 1);

    // filter: acc += in*4/2 - acc/4 gives tau of 4 cycles, 200 ns
    localparam logic [3:0]  FILT_STEP    = 4'h2;
    localparam logic [3:0]  FILT_HI      = 4'h6;
    localparam logic [3:0]  FILT_LO      = 4'h2;

    // ------------------------------------------------------------------
    // reset values and types
    // ------------------------------------------------------------------
    localparam logic        IDLE_RST     = 1'b1;
    localparam logic        FILT_LVL_RST = 1'b1;   // line idles high, pulled
    localparam logic [1:0]  BUF_DEPTH    = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BIT  = 2'h1,
        ST_HOLD = 2'h2,
        ST_FRS  = 2'h3
    } bclt_state_t;

    // one data bit handed to the transmitter, with end-of-frame mark
    typedef struct packed {
        logic last;
        logic data_bit;
    } bclt_word_t;

    // line drive towards the pad
    typedef struct packed {
        logic oe;
        logic lvl;
    } bclt_drive_t;

endpackage

// [bclt_core.sv]
// cc line timing: bmc sender with gap and idle check, activity and role swap detect
`timescale 1ns/10ps

// Overview of operation
// - release driver before inter-frame gap elapses
// - hold bit rate within drift of preamble
// - same drift limit for every packet type
// - stop driving within end-of-drive time
// - wait inter-frame gap after tx, rx, idle
// - check bus idle right before driving
// - start may shift by start tolerance
// - role swap: drive cc low full duration
// - send swap pulse only under explicit contract
// - swap pulse discards all pending messages
// - swap pulse overrides any running transmission
// - after pulse advertise sink may transmit
// - low for detect time means swap request
// - three transitions in window means active
// - window without three transitions means idle
// - single pole filter, tau at least 100ns
// - inter-frame gap at least 25 us
// - release line within 23 us after last
// - swap pulse lasts 60 to 120 us
// - start drive within one microsecond of nominal
module bclt_core (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_ce,
    input  wire logic                i_valid,
    input  wire bclt_pkg::bclt_word_t i_word,
    output logic                     o_ready,
    input  wire logic                i_cc_in,
    output logic                     o_cc_out,
    output logic                     o_cc_oe,
    input  wire logic                i_rx_frame_end,
    input  wire logic                i_frs_req,
    input  wire logic                i_explicit_contract,
    input  wire logic                i_advert_clear,
    output logic                     o_sink_may_transmit_advert,
    output logic                     o_discard,
    output logic                     o_frame_done,
    output logic                     o_bus_idle,
    output logic                     o_frs_detected,
    output logic                     o_tx_busy
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        bclt_pkg::bclt_state_t st;
        bclt_pkg::bclt_word_t  buf0;
        bclt_pkg::bclt_word_t  buf1;
        logic [1:0]            buf_cnt;
        bclt_pkg::bclt_word_t  cur;
        logic                  phase;
        logic [10:0]           tmr;
        bclt_pkg::bclt_drive_t drv;
        logic [9:0]            gap_cnt;
        logic [3:0]            filt_acc;
        logic                  filt_lvl;
        logic                  filt_prev;
        logic [8:0]            win_cnt;
        logic [1:0]            trans_cnt;
        logic                  idle;
        logic [9:0]            low_cnt;
        logic                  frs_det;
        logic                  advert;
        logic                  discard;
        logic                  frame_done;
    } bclt_state_all_t;

    bclt_state_all_t q_ff;
    bclt_state_all_t nxt_q;

    logic push;
    logic trans;

    // buffer takes a word only outside the swap pulse and while it has room
    assign o_ready = (q_ff.buf_cnt != bclt_pkg::BUF_DEPTH) && (q_ff.st != bclt_pkg::ST_FRS);
    assign push    = i_valid && o_ready;
    assign trans   = q_ff.filt_lvl != q_ff.filt_prev;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic pop;
        logic gap_restart;
        bclt_pkg::bclt_word_t head;
        pop         = 1'b0;
        gap_restart = 1'b0;
        head        = q_ff.buf0;
        nxt_q       = q_ff;
        nxt_q.discard    = 1'b0;
        nxt_q.frame_done = 1'b0;
        nxt_q.frs_det    = 1'b0;

        // single pole filter on the cc input, tau 4 cycles
        // decay of at least one step, else acc stalls at 3 and the level never falls
        nxt_q.filt_acc  = q_ff.filt_acc - ((q_ff.filt_acc >> 2) | {3'h0, |q_ff.filt_acc})
                          + (i_cc_in ? bclt_pkg::FILT_STEP : 4'h0);
        nxt_q.filt_prev = q_ff.filt_lvl;
        // hysteresis keeps slow edges from counting twice
        if (q_ff.filt_acc >= bclt_pkg::FILT_HI) begin
            nxt_q.filt_lvl = 1'b1;
        end else if (q_ff.filt_acc <= bclt_pkg::FILT_LO) begin
            nxt_q.filt_lvl = 1'b0;
        end

        // activity window: restart on expiry or on declared activity
        if (trans && (q_ff.trans_cnt == bclt_pkg::TRANS_LAST)) begin
            nxt_q.idle      = 1'b0;
            nxt_q.win_cnt   = 9'h000;
            nxt_q.trans_cnt = 2'h0;
        end else if (q_ff.win_cnt == bclt_pkg::WIN_CYC - 9'h001) begin
            nxt_q.idle      = 1'b1;
            nxt_q.win_cnt   = 9'h000;
            nxt_q.trans_cnt = 2'h0;
        end else begin
            nxt_q.win_cnt   = q_ff.win_cnt + 9'h001;
            nxt_q.trans_cnt = q_ff.trans_cnt + (trans ? 2'h1 : 2'h0);
        end

        // role swap detect: continuous low, own drive masked
        if (q_ff.filt_lvl || q_ff.drv.oe) begin
            nxt_q.low_cnt = 10'h000;
        end else if (q_ff.low_cnt != bclt_pkg::FRS_RX_CYC) begin
            nxt_q.low_cnt = q_ff.low_cnt + 10'h001;
            if (q_ff.low_cnt == bclt_pkg::FRS_RX_CYC - 10'h001) begin
                nxt_q.frs_det = 1'b1;
            end
        end

        if (i_advert_clear) begin
            nxt_q.advert = 1'b0;
        end

        // transmit sequencer
        case (q_ff.st)
            bclt_pkg::ST_IDLE: begin
                // start only after the gap and on a quiet bus
                if ((q_ff.buf_cnt != 2'h0) && (q_ff.gap_cnt == bclt_pkg::GAP_CYC) && q_ff.idle) begin
                    pop           = 1'b1;
                    nxt_q.cur     = head;
                    nxt_q.st      = bclt_pkg::ST_BIT;
                    nxt_q.tmr     = 11'h000;
                    nxt_q.phase   = 1'b0;
                    nxt_q.drv.oe  = 1'b1;                   // nominal start, no shift
                    nxt_q.drv.lvl = ~q_ff.drv.lvl;
                end
            end
            bclt_pkg::ST_BIT: begin
                // fixed half-cell timer: zero drift by construction
                if (q_ff.tmr == bclt_pkg::HALF_UI_CYC - 11'h001) begin
                    nxt_q.tmr = 11'h000;
                    if (!q_ff.phase) begin
                        nxt_q.phase = 1'b1;
                        if (q_ff.cur.data_bit) begin
                            nxt_q.drv.lvl = ~q_ff.drv.lvl;
                        end
                    end else if (!q_ff.cur.last && (q_ff.buf_cnt != 2'h0)) begin
                        pop           = 1'b1;
                        nxt_q.cur     = head;
                        nxt_q.phase   = 1'b0;
                        nxt_q.drv.lvl = ~q_ff.drv.lvl;
                    end else begin
                        // last bit or underrun both close the frame low
                        nxt_q.st      = bclt_pkg::ST_HOLD;
                        nxt_q.drv.lvl = 1'b0;
                    end
                end else begin
                    nxt_q.tmr = q_ff.tmr + 11'h001;
                end
            end
            bclt_pkg::ST_HOLD: begin
                // hold low then release, far inside end-of-drive
                if (q_ff.tmr == bclt_pkg::HOLD_CYC - 11'h001) begin
                    nxt_q.st         = bclt_pkg::ST_IDLE;
                    nxt_q.drv.oe     = 1'b0;
                    nxt_q.tmr        = 11'h000;
                    nxt_q.frame_done = 1'b1;
                    gap_restart      = 1'b1;
                end else begin
                    nxt_q.tmr = q_ff.tmr + 11'h001;
                end
            end
            bclt_pkg::ST_FRS: begin
                // hard low for the whole pulse
                nxt_q.drv.lvl = 1'b0;
                if (q_ff.tmr == bclt_pkg::FRS_TX_CYC - 11'h001) begin
                    nxt_q.st     = bclt_pkg::ST_IDLE;
                    nxt_q.drv.oe = 1'b0;
                    nxt_q.tmr    = 11'h000;
                    nxt_q.advert = 1'b1;
                    gap_restart  = 1'b1;
                end else begin
                    nxt_q.tmr = q_ff.tmr + 11'h001;
                end
            end
            default: begin
                nxt_q.st     = bclt_pkg::ST_IDLE;
                nxt_q.drv.oe = 1'b0;
            end
        endcase

        // buffer update, two entries
        if (pop && push) begin
            nxt_q.buf0 = (q_ff.buf_cnt == 2'h2) ? q_ff.buf1 : i_word;
            nxt_q.buf1 = i_word;
        end else if (pop) begin
            nxt_q.buf0    = q_ff.buf1;
            nxt_q.buf_cnt = q_ff.buf_cnt - 2'h1;
        end else if (push) begin
            if (q_ff.buf_cnt == 2'h0) begin
                nxt_q.buf0 = i_word;
            end else begin
                nxt_q.buf1 = i_word;
            end
            nxt_q.buf_cnt = q_ff.buf_cnt + 2'h1;
        end

        // role swap request wins over any frame in flight
        if (i_frs_req && i_explicit_contract && (q_ff.st != bclt_pkg::ST_FRS)) begin
            nxt_q.st      = bclt_pkg::ST_FRS;
            nxt_q.tmr     = 11'h000;
            nxt_q.drv.oe  = 1'b1;
            nxt_q.drv.lvl = 1'b0;
            nxt_q.buf_cnt = 2'h0;
            nxt_q.discard = 1'b1;
            nxt_q.advert  = 1'b0;
            gap_restart   = 1'b0;
        end

        // gap counts from own end, received end or fresh idle
        if (gap_restart || i_rx_frame_end || (nxt_q.idle && !q_ff.idle)) begin
            nxt_q.gap_cnt = 10'h000;
        end else if (q_ff.gap_cnt != bclt_pkg::GAP_CYC) begin
            nxt_q.gap_cnt = q_ff.gap_cnt + 10'h001;
        end
    end

    // ------------------------------------------------------------------
    // registers, frozen while the clock enable is low
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_ff           <= '0;
            q_ff.idle      <= bclt_pkg::IDLE_RST;
            q_ff.gap_cnt   <= bclt_pkg::GAP_CYC;
            // filter starts settled at the idle-high line, so no false edge follows reset
            q_ff.filt_acc  <= bclt_pkg::FILT_HI;
            q_ff.filt_lvl  <= bclt_pkg::FILT_LVL_RST;
            q_ff.filt_prev <= bclt_pkg::FILT_LVL_RST;
        end else if (i_ce) begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from flip-flops, busy decoded from the state
    assign o_cc_out                   = q_ff.drv.lvl;
    assign o_cc_oe                    = q_ff.drv.oe;
    assign o_sink_may_transmit_advert = q_ff.advert;
    assign o_discard                  = q_ff.discard;
    assign o_frame_done               = q_ff.frame_done;
    assign o_bus_idle                 = q_ff.idle;
    assign o_frs_detected             = q_ff.frs_det;
    assign o_tx_busy                  = q_ff.st != bclt_pkg::ST_IDLE;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // no drive at all while the sequencer rests
    property p_released_in_idle;
        q_ff.st == bclt_pkg::ST_IDLE |-> !o_cc_oe;
    endproperty
    a_released_in_idle: assert property (p_released_in_idle) else $error("driver left on in idle");

    // half-cell timer never runs past its count
    property p_half_cell;
        q_ff.st == bclt_pkg::ST_BIT |-> q_ff.tmr < bclt_pkg::HALF_UI_CYC;
    endproperty
    a_half_cell: assert property (p_half_cell) else $error("bit cell too long");

    // release after the last bit well inside end-of-drive
    property p_end_drive;
        q_ff.st == bclt_pkg::ST_HOLD |-> o_cc_oe && !o_cc_out && (q_ff.tmr < bclt_pkg::END_DRV_CYC);
    endproperty
    a_end_drive: assert property (p_end_drive) else $error("end of drive too late");

    // a frame starts only after a full gap on an idle bus
    property p_gap_before_start;
        $rose(o_cc_oe) && (q_ff.st == bclt_pkg::ST_BIT) |-> $past(q_ff.gap_cnt) == bclt_pkg::GAP_CYC;
    endproperty
    a_gap_before_start: assert property (p_gap_before_start) else $error("gap too short");

    property p_idle_before_start;
        $rose(o_cc_oe) && (q_ff.st == bclt_pkg::ST_BIT) |-> $past(q_ff.idle);
    endproperty
    a_idle_before_start: assert property (p_idle_before_start) else $error("started on busy bus");

    // swap pulse: low, driven, bounded length
    property p_frs_pulse;
        q_ff.st == bclt_pkg::ST_FRS |-> o_cc_oe && !o_cc_out && (q_ff.tmr < bclt_pkg::FRS_TX_CYC);
    endproperty
    a_frs_pulse: assert property (p_frs_pulse) else $error("swap pulse malformed");

    property p_frs_contract;
        $rose(q_ff.st == bclt_pkg::ST_FRS) |-> $past(i_explicit_contract) && $past(i_frs_req);
    endproperty
    a_frs_contract: assert property (p_frs_contract) else $error("swap pulse without contract");

    property p_frs_discard;
        $rose(q_ff.st == bclt_pkg::ST_FRS) |-> o_discard && (q_ff.buf_cnt == 2'h0);
    endproperty
    a_frs_discard: assert property (p_frs_discard) else $error("pending words kept");

    property p_frs_advert;
        $fell(q_ff.st == bclt_pkg::ST_FRS) |-> o_sink_may_transmit_advert && !o_cc_oe;
    endproperty
    a_frs_advert: assert property (p_frs_advert) else $error("advert not set after pulse");

    property p_frs_detect;
        o_frs_detected |-> $past(q_ff.low_cnt) == bclt_pkg::FRS_RX_CYC - 10'h001;
    endproperty
    a_frs_detect: assert property (p_frs_detect) else $error("swap detect at wrong time");

    property p_active;
        i_ce && trans && (q_ff.trans_cnt == bclt_pkg::TRANS_LAST) |=> !o_bus_idle && (q_ff.win_cnt == 9'h000);
    endproperty
    a_active: assert property (p_active) else $error("activity not declared");

    // covers of the main scenarios
    c_frame_done: cover property (o_frame_done);
    c_frs_sent:   cover property ($fell(q_ff.st == bclt_pkg::ST_FRS));
    c_frs_seen:   cover property (o_frs_detected);
    c_active:     cover property ($fell(o_bus_idle));

endmodule

// [bclt_partner.sv]
// far-side transceiver model on the cc wire
`timescale 1ns/10ps
module bclt_partner (
    input  wire logic i_clk,
    input  wire logic i_dut_oe,
    input  wire logic i_dut_lvl,
    input  wire logic i_toggle,
    input  wire logic i_hold_low,
    output logic      o_line
);
    logic       lvl_ff = 1'h1;
    logic [5:0] cnt_ff = 6'h0;
    // ---------------------------------------------
    // edges every half cell while talking
    // ---------------------------------------------
    always @(posedge i_clk) begin
        if (i_toggle && cnt_ff == 6'(bclt_pkg::HALF_UI_CYC - 11'h1)) begin
            lvl_ff <= ~lvl_ff;
            cnt_ff <= 6'h0;
        end else begin
            cnt_ff <= i_toggle ? cnt_ff + 6'h1 : 6'h0;
        end
    end
    // wired line: device wins, then far-end low or toggling, else the pulled level
    assign o_line = i_dut_oe ? i_dut_lvl : (i_hold_low ? 1'h0 : (i_toggle ? lvl_ff : 1'h1));
endmodule

// [tb_top.sv]
// self-checking bench for the cc line timing block
`timescale 1ns/10ps
module tb_top;
    localparam int TX_MIN = bclt_pkg::FRS_TX_MIN_NS / bclt_pkg::CLK_NS;
    localparam int TX_MAX = bclt_pkg::FRS_TX_MAX_NS / bclt_pkg::CLK_NS;
    localparam int RX_MIN = bclt_pkg::FRS_RX_MIN_NS / bclt_pkg::CLK_NS;
    localparam int RX_MAX = bclt_pkg::FRS_RX_MAX_NS / bclt_pkg::CLK_NS;
    localparam int WIN    = bclt_pkg::WIN_MAX_NS / bclt_pkg::CLK_NS;
    logic                 clk = 1'h0;
    logic                 rst_n = 1'h0;
    logic                 valid = 1'h0;
    bclt_pkg::bclt_word_t word = '0;
    logic                 rx_end = 1'h0;
    logic                 frs_req = 1'h0;
    logic                 contract = 1'h0;
    logic                 adv_clr = 1'h0;
    logic                 ce = 1'h1;
    logic                 p_tog = 1'h0;
    logic                 p_low = 1'h0;
    logic                 ready, cc_in, cc_out, oe, adv, discard, fdone, idle, frs_det, busy;
    logic                 oe_d, idle_d, in_swap, abort;
    int                   error_cnt = 0;
    int                   checks_done = 0;
    int                   exp_q[$];
    int                   gap_cnt, low_run, swp_cnt, in_low, refused, k;

    always #25 clk = ~clk;

    bclt_core u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_valid(valid), .i_word(word),
        .o_ready(ready), .i_cc_in(cc_in), .o_cc_out(cc_out), .o_cc_oe(oe), .i_rx_frame_end(rx_end),
        .i_frs_req(frs_req), .i_explicit_contract(contract), .i_advert_clear(adv_clr),
        .o_sink_may_transmit_advert(adv), .o_discard(discard), .o_frame_done(fdone),
        .o_bus_idle(idle), .o_frs_detected(frs_det), .o_tx_busy(busy));

    bclt_partner u_far (.i_clk(clk), .i_dut_oe(oe), .i_dut_lvl(cc_out), .i_toggle(p_tog),
        .i_hold_low(p_low), .o_line(cc_in));

    // ---------------------------------------------
    // compare, verdict
    // ---------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic int pop_ev();
        return (exp_q.size() != 0) ? exp_q.pop_front() : 0;
    endfunction

    // word driver; stops offering once a swap flushed the buffer
    task automatic send_frame(input int n);
        abort = 1'h0;
        for (int b = 0; b < n && !abort; b++) begin
            valid = 1'h1;
            word.data_bit = 1'($urandom);
            word.last = (b == n - 1);
            for (int w = 0; w < 20000 && ready !== 1'h1 && !abort; w++) begin
                refused++;
                @(negedge clk);
            end
            @(negedge clk);
        end
        valid = 1'h0;
    endtask

    // a queued frame may wait for gap and idle: see it start, then finish
    task automatic wait_done;
        for (k = 0; k < 3000 && busy !== 1'h1; k++) @(negedge clk);
        for (k = 0; k < 3000 && busy !== 1'h0; k++) @(negedge clk);
        chk("tx_finished", busy, 1'h0);
    endtask

    // ---------------------------------------------
    // monitor: event queue, gap, hold, pulse widths
    // ---------------------------------------------
    always @(posedge clk) begin
        #1;
        if (!rst_n) begin
            gap_cnt = 100000;
            in_swap = 1'h0;
        end else begin
            gap_cnt++;
            if (oe === 1'h1 && oe_d === 1'h0 && discard !== 1'h1) begin
                chk("gap", gap_cnt >= bclt_pkg::GAP_CYC, 1);
                chk("idle_before_start", idle_d, 1'h1);
            end
            if (fdone === 1'h1) begin
                chk("frame_done", 1, pop_ev());
                chk("hold_low", low_run >= bclt_pkg::HOLD_CYC && low_run <= bclt_pkg::END_DRV_CYC, 1);
                chk("released", oe, 1'h0);
            end
            if (fdone === 1'h1 || rx_end === 1'h1 || (idle === 1'h1 && idle_d === 1'h0)) gap_cnt = 0;
            if (oe === 1'h1) low_run = (cc_out === 1'h0) ? low_run + 1 : 0;
            if (discard === 1'h1) begin
                chk("discard", 2, pop_ev());
                in_swap = 1'h1;
                swp_cnt = 0;
                abort = 1'h1;
            end
            if (in_swap && oe === 1'h1) begin
                swp_cnt++;
                chk("swap_level", cc_out, 1'h0);
            end else if (in_swap) begin
                in_swap = 1'h0;
                chk("swap_len", swp_cnt >= TX_MIN && swp_cnt <= TX_MAX, 1);
                chk("advert_set", adv, 1'h1);
            end
            in_low = (oe === 1'h0 && cc_in === 1'h0) ? in_low + 1 : 0;
            if (frs_det === 1'h1) begin
                chk("swap_seen", 3, pop_ev());
                chk("swap_seen_time", in_low >= RX_MIN && in_low <= RX_MAX, 1);
            end
        end
        oe_d = oe;
        idle_d = idle;
    end

    // hang guard, well beyond the expected run
    initial begin
        #(50 * 60000);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        wrap_up();
    end

    // ---------------------------------------------
    // main sequence, inputs change at falling edges
    // ---------------------------------------------
    initial begin
        void'($urandom(32'hA02FE657));
        refused = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'h1;
        chk("rst_idle", idle, 1'h1);
        chk("rst_oe", oe, 1'h0);
        chk("rst_advert", adv, 1'h0);
        // back-to-back frames, buffer must push back
        exp_q.push_back(1);
        send_frame(6);
        chk("buffer_full_seen", refused > 0, 1);
        wait_done();
        chk("drained", ready, 1'h1);
        exp_q.push_back(1);
        send_frame(3);
        wait_done();
        // received frame end restarts the gap
        rx_end = 1'h1;
        @(negedge clk);
        rx_end = 1'h0;
        exp_q.push_back(1);
        send_frame(2);
        wait_done();
        // two edges in a window are not activity; start from a quiet bus
        for (k = 0; k < 3 * WIN && idle !== 1'h1; k++) @(negedge clk);
        p_tog = 1'h1;
        repeat (70) @(negedge clk);
        p_tog = 1'h0;
        repeat (20) @(negedge clk);
        chk("two_edges_idle", idle, 1'h1);
        // far end talks: active, frame held back until idle
        p_tog = 1'h1;
        for (k = 0; k < 2 * WIN && idle !== 1'h0; k++) @(negedge clk);
        chk("active", idle, 1'h0);
        exp_q.push_back(1);
        send_frame(2);
        // random freezes and stray strobes must not let the frame out
        for (k = 0; k < 300; k++) begin
            ce      = 1'($urandom);
            rx_end  = ($urandom % 64) == 0;
            adv_clr = 1'($urandom);
            @(negedge clk);
        end
        ce      = 1'h1;
        rx_end  = 1'h0;
        adv_clr = 1'h0;
        chk("held_back", oe, 1'h0);
        chk("advert_quiet", adv, 1'h0);
        p_tog = 1'h0;
        for (k = 0; k < 3 * WIN && idle !== 1'h1; k++) @(negedge clk);
        chk("idle_again", k <= 2 * WIN + 8, 1);
        wait_done();
        // swap request without a contract is ignored
        frs_req = 1'h1;
        repeat (10) @(negedge clk);
        frs_req = 1'h0;
        chk("no_contract", oe, 1'h0);
        // swap cuts a running frame
        contract = 1'h1;
        exp_q.push_back(2);
        fork
            send_frame(8);
            begin
                for (k = 0; k < 3000 && oe !== 1'h1; k++) @(negedge clk);
                repeat (100) @(negedge clk);
                frs_req = 1'h1;
                @(negedge clk);
                frs_req = 1'h0;
            end
        join
        wait_done();
        chk("advert", adv, 1'h1);
        adv_clr = 1'h1;
        @(negedge clk);
        adv_clr = 1'h0;
        @(negedge clk);
        chk("advert_clr", adv, 1'h0);
        repeat (800) @(negedge clk);
        chk("flushed", oe, 1'h0);
        // short low restarts, long low is a swap request
        p_low = 1'h1;
        repeat (400) @(negedge clk);
        p_low = 1'h0;
        repeat (20) @(negedge clk);
        exp_q.push_back(3);
        p_low = 1'h1;
        repeat (900) @(negedge clk);
        p_low = 1'h0;
        repeat (20) @(negedge clk);
        chk("events_left", exp_q.size(), 0);
        wrap_up();
    end
endmodule
